// [rtl/rpd_pkg.sv]
// rpd_pkg: constants for the random port decode block.
// assumes one 10 MHz clock; no software-visible bus.
`default_nettype none
package rpd_pkg;
  localparam int          ADDR_W      = 13;
  localparam int          DATA_W      = 16;
  localparam int          REG_W       = 13;
  localparam int          DEPTH       = 8192;
  localparam logic [2:0]  CMD_START1  = 3'h0;
  localparam logic [2:0]  CMD_END1    = 3'h1;
  localparam logic [2:0]  CMD_START2  = 3'h2;
  localparam logic [2:0]  CMD_END2    = 3'h3;
  localparam logic [2:0]  CMD_FLOW    = 3'h4;
  localparam logic [2:0]  CMD_FLAG    = 3'h5;
  localparam logic [12:0] RST_START1  = 13'h0000;
  localparam logic [12:0] RST_END1    = 13'h0fff;
  localparam logic [12:0] RST_START2  = 13'h1000;
  localparam logic [12:0] RST_END2    = 13'h1fff;
  localparam logic [3:0]  RST_FLOW    = 4'h0;
  localparam int          FLAG1_BIT   = 0;
  localparam int          FLAG2_BIT   = 1;
  localparam int          LO_TOP      = 7;
  localparam int          HI_BOT      = 8;
endpackage : rpd_pkg
`default_nettype wire

// [rtl/rpd_port.sv]
// rpd_port: random port decode with array, command registers and the
// sequential pointer/end flags. all inputs but clk and rst_n are pins: synchronised by
// three flops, a change counting once stages two and three agree.
// Function
// - low-lane read floats high lane
// - high-lane read floats low lane
// - selected write with both lanes on stores both lanes
// - single-lane write updates only that byte
// - deselect floats lanes, enters power-down
// - output drive high floats, no power-down
// - both lanes off: float, no access
// - command write loads selected register
// - command read drives register contents
// - command access allowed per lane
// - random port ignores sequential signals
// - sequential power-down needs registered select
// - advance read drives first end flag
// - low address bits pick command register
// - end flags set on match, cleared
`default_nettype none
module rpd_port
  import rpd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              port_select_n,
  input  wire logic              cmd_select_n,
  input  wire logic              write_not_read,
  input  wire logic              output_drive_n,
  input  wire logic              low_lane_n,
  input  wire logic              high_lane_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic      [1:0]        data_oe,
  output logic                   rand_power_down,
  input  wire logic              seq_port_select_n,
  input  wire logic              pointer_advance_n,
  input  wire logic              seq_write_not_read,
  input  wire logic              seq_output_drive_n,
  output logic                   seq_power_down,
  output logic      [ADDR_W-1:0] pointer,
  output logic                   end_flag_one_n,
  output logic                   end_flag_two_n
);
  localparam int NCTL = 10;
  localparam int SW   = NCTL + ADDR_W + DATA_W;
  logic [SW-1:0] s1, s2, s3, st;
  logic [SW-1:0] raw;
  assign raw = {port_select_n, cmd_select_n, write_not_read, output_drive_n,
                low_lane_n, high_lane_n, seq_port_select_n,
                pointer_advance_n, seq_write_not_read, seq_output_drive_n,
                addr, data_in};
  // three-stage sync; stable copy updates only when stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= {SW{1'b1}};
      s2 <= {SW{1'b1}};
      s3 <= {SW{1'b1}};
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  for (genvar i = 0; i < SW; i++) begin : g_stab
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        st[i] <= 1'b1;
      end else if (s2[i] == s3[i]) begin
        st[i] <= s3[i];
      end
    end
  end
  logic              ce_n, cmd_n, wnr, oe_n, lb_n, ub_n;
  logic              sce_n, adv_n, swnr, soe_n;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] d;
  assign {ce_n, cmd_n, wnr, oe_n, lb_n, ub_n, sce_n, adv_n, swnr, soe_n,
          a, d} = st;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [REG_W-1:0]  start1, end1, start2, end2;
  logic [3:0]        flow;
  logic              arr_sel, cmd_sel;
  // random decode uses only random-port pins
  assign arr_sel = !ce_n && cmd_n && !(lb_n && ub_n);
  // host keeps selects exclusive; both low does nothing
  // command access on either lane or both
  assign cmd_sel = ce_n && !cmd_n && !(lb_n && ub_n);

  always_ff @(posedge clk) begin
    if (arr_sel && !wnr) begin
      if (!lb_n) mem[a][LO_TOP:0] <= d[LO_TOP:0];
      if (!ub_n) mem[a][DATA_W-1:HI_BOT] <= d[DATA_W-1:HI_BOT];
    end
  end

  logic flag_clr1, flag_clr2;
  // command write, register select by low address bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start1 <= RST_START1;
      end1   <= RST_END1;
      start2 <= RST_START2;
      end2   <= RST_END2;
      flow   <= RST_FLOW;
    end else if (cmd_sel && !wnr) begin
      unique case (a[2:0])
        CMD_START1: start1 <= d[REG_W-1:0];
        CMD_END1:   end1   <= d[REG_W-1:0];
        CMD_START2: start2 <= d[REG_W-1:0];
        CMD_END2:   end2   <= d[REG_W-1:0];
        CMD_FLOW:   flow   <= d[3:0];
        default:    ;
      endcase
    end
  end
  // writing zero to a flag bit clears it
  assign flag_clr1 = cmd_sel && !wnr && a[2:0] == CMD_FLAG
                     && !d[FLAG1_BIT];
  assign flag_clr2 = cmd_sel && !wnr && a[2:0] == CMD_FLAG
                     && !d[FLAG2_BIT];

  logic [DATA_W-1:0] cmd_rd;
  // bits above the register read back high
  always_comb begin
    cmd_rd = {DATA_W{1'b1}};
    unique case (a[2:0])
      CMD_START1: cmd_rd[REG_W-1:0] = start1;
      CMD_END1:   cmd_rd[REG_W-1:0] = end1;
      CMD_START2: cmd_rd[REG_W-1:0] = start2;
      CMD_END2:   cmd_rd[REG_W-1:0] = end2;
      CMD_FLOW:   cmd_rd[REG_W-1:0] = {{(REG_W-4){1'b0}}, flow};
      CMD_FLAG:   cmd_rd[REG_W-1:0] = {{(REG_W-2){1'b0}}, end_flag_two_n,
                                       end_flag_one_n};
      default:    cmd_rd[REG_W-1:0] = {REG_W{1'b0}};
    endcase
  end

  logic rd_go;
  // host holds drive high while writing; lanes follow read only
  assign rd_go = wnr && !oe_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= {DATA_W{1'b0}};
      data_oe  <= 2'b00;
    end else begin
      data_oe  <= {rd_go && !ub_n && (arr_sel || cmd_sel),
                   rd_go && !lb_n && (arr_sel || cmd_sel)};
      data_out <= cmd_sel ? cmd_rd : mem[a];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rand_power_down <= 1'b1;
    else rand_power_down <= ce_n && cmd_n;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) seq_power_down <= 1'b1;
    else seq_power_down <= sce_n;
  end
  logic [ADDR_W-1:0] next_pointer;
  assign next_pointer = ADDR_W'(pointer + 1'b1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pointer <= {ADDR_W{1'b0}};
    else if (!adv_n) pointer <= next_pointer;
  end
  // flags fall on advanced match; set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_flag_one_n <= 1'b1;
      end_flag_two_n <= 1'b1;
    end else begin
      if (!adv_n && next_pointer == end1) end_flag_one_n <= 1'b0;
      else if (flag_clr1) end_flag_one_n <= 1'b1;
      if (!adv_n && next_pointer == end2) end_flag_two_n <= 1'b0;
      else if (flag_clr2) end_flag_two_n <= 1'b1;
    end
  end

  // deselect leaves lanes floating next cycle
  deselect_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce_n && cmd_n) |=> data_oe == 2'b00) else $error("lanes driven");
  oe_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    oe_n |=> data_oe == 2'b00) else $error("lanes driven with oe high");
  low_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    (arr_sel && rd_go && !lb_n && ub_n) |=> data_oe == 2'b01)
    else $error("low lane read wrong");
  high_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    (arr_sel && rd_go && lb_n && !ub_n) |=> data_oe == 2'b10)
    else $error("high lane read wrong");
  cmd_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_sel && rd_go) |=> data_out[DATA_W-1:REG_W] == '1)
    else $error("upper bits not high");
  flag_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!adv_n && next_pointer == end1) |=> !end_flag_one_n)
    else $error("end flag one missed");
  seq_pd_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sce_n) |=> seq_power_down) else $error("no seq power-down");
  no_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ce_n && lb_n && ub_n) |=> (data_oe == 2'b00 && !rand_power_down))
    else $error("no-access case wrong");
endmodule : rpd_port
`default_nettype wire

// [sim/random_port_access_decode_tb_top.sv]
// bench for rpd_port: table of host accesses, then end flag case.
// assumes rpd_host drives the random pins; bench drives the rest.
`default_nettype none
module random_port_access_decode_tb_top
  import rpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0]        o;
    logic [1:0]        l;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [1:0]        oe;
    logic              pd;
    logic [DATA_W-1:0] q;
  } rpd_row_s;
  logic              clk       = 1'b0;
  logic              rst_n     = 1'b0;
  logic              sel_n     = 1'b1;
  logic              adv_n     = 1'b1;
  logic [2:0]        op        = 3'h0;
  logic [1:0]        lanes_n   = 2'h0;
  logic [ADDR_W-1:0] ha        = 13'h0000;
  logic [DATA_W-1:0] hd        = 16'h0000;
  int                fails     = 0;
  int                cmp_count = 0;
  int                cycles    = 0;
  wire logic ps_n, cs_n, wnr, od_n, lo_n, hi_n, spd, f1_n, f2_n, rpd;
  wire logic [12:0] addr, ptr;
  wire logic [15:0] din, dout;
  wire logic [1:0] oe;
  // op, lanes_n {high, low}, addr, data, expected oe, power-down, data
  rpd_row_s rows [23] = '{
    '{3'h2, 2'h0, 13'h0005, 16'h1234, 2'h0, 1'b0, 16'h0000},
    '{3'h1, 2'h0, 13'h0005, 16'h0000, 2'h3, 1'b0, 16'h1234},
    '{3'h2, 2'h2, 13'h0005, 16'habcd, 2'h0, 1'b0, 16'h0000},
    '{3'h1, 2'h2, 13'h0005, 16'h0000, 2'h1, 1'b0, 16'h12cd},
    '{3'h1, 2'h1, 13'h0005, 16'h0000, 2'h2, 1'b0, 16'h12cd},
    '{3'h2, 2'h1, 13'h0005, 16'h5600, 2'h0, 1'b0, 16'h0000},
    '{3'h1, 2'h0, 13'h0005, 16'h0000, 2'h3, 1'b0, 16'h56cd},
    '{3'h5, 2'h0, 13'h0005, 16'h0000, 2'h0, 1'b0, 16'h0000},
    '{3'h1, 2'h3, 13'h0005, 16'h0000, 2'h0, 1'b0, 16'h0000},
    '{3'h2, 2'h3, 13'h0005, 16'hffff, 2'h0, 1'b0, 16'h0000},
    '{3'h1, 2'h0, 13'h0005, 16'h0000, 2'h3, 1'b0, 16'h56cd},
    '{3'h0, 2'h0, 13'h0005, 16'h0000, 2'h0, 1'b1, 16'h0000},
    '{3'h4, 2'h0, 13'h1ff9, 16'hfabc, 2'h0, 1'b0, 16'h0000},
    '{3'h3, 2'h0, 13'h1ff9, 16'h0000, 2'h3, 1'b0, 16'hfabc},
    '{3'h3, 2'h2, 13'h0000, 16'h0000, 2'h1, 1'b0, 16'he000},
    '{3'h3, 2'h1, 13'h0000, 16'h0000, 2'h2, 1'b0, 16'he000},
    '{3'h4, 2'h0, 13'h0006, 16'h0123, 2'h0, 1'b0, 16'h0000},
    '{3'h3, 2'h0, 13'h0007, 16'h0000, 2'h3, 1'b0, 16'he000},
    '{3'h3, 2'h0, 13'h0002, 16'h0000, 2'h3, 1'b0, 16'hf000},
    '{3'h3, 2'h0, 13'h0003, 16'h0000, 2'h3, 1'b0, 16'hffff},
    '{3'h4, 2'h0, 13'h0004, 16'h0005, 2'h0, 1'b0, 16'h0000},
    '{3'h3, 2'h0, 13'h0004, 16'h0000, 2'h3, 1'b0, 16'he005},
    '{3'h0, 2'h3, 13'h0000, 16'h0000, 2'h0, 1'b1, 16'h0000}};
  initial forever #50 clk = ~clk;
  rpd_host i_host (.clk(clk), .op(op), .lanes_n(lanes_n), .a(ha), .d(hd),
    .port_select_n(ps_n), .cmd_select_n(cs_n), .write_not_read(wnr),
    .output_drive_n(od_n), .low_lane_n(lo_n), .high_lane_n(hi_n),
    .addr(addr), .data_in(din));
  rpd_port i_dut (.clk(clk), .rst_n(rst_n), .port_select_n(ps_n),
    .cmd_select_n(cs_n), .write_not_read(wnr), .output_drive_n(od_n),
    .low_lane_n(lo_n), .high_lane_n(hi_n), .addr(addr), .data_in(din),
    .data_out(dout), .data_oe(oe), .rand_power_down(rpd),
    .seq_port_select_n(sel_n), .pointer_advance_n(adv_n),
    .seq_write_not_read(1'b1), .seq_output_drive_n(1'b0),
    .seq_power_down(spd), .pointer(ptr), .end_flag_one_n(f1_n),
    .end_flag_two_n(f2_n));
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // pins settle after the host flop plus four synchroniser edges
  task automatic acc(input rpd_row_s r);
    @(posedge clk);
    op      <= r.o;
    lanes_n <= r.l;
    ha      <= r.a;
    hd      <= r.d;
    repeat (9) @(posedge clk);
    #1;
  endtask : acc
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    rpd_row_s          w;
    logic [DATA_W-1:0] m;
    @(posedge clk);
    #1;
    chk({10'h0, oe, rpd, spd, f1_n, f2_n}, 16'h000f);
    chk({3'h0, ptr}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      acc(rows[i]);
      // only lanes that the row expects driven carry data
      m = {{8{rows[i].oe[1]}}, {8{rows[i].oe[0]}}};
      chk({13'h0, oe, rpd}, {13'h0, rows[i].oe, rows[i].pd});
      chk(dout & m, rows[i].q & m);
    end
    w = '{3'h4, 2'h0, 13'h0001, 16'h0010, 2'h0, 1'b0, 16'h0000};
    acc(w);
    // 40 advance cycles: passes end address 0x10 once
    @(posedge clk);
    sel_n <= 1'b0;
    adv_n <= 1'b0;
    repeat (40) @(posedge clk);
    adv_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({13'h0, f1_n, f2_n, spd}, 16'h0002);
    chk({3'h0, ptr}, 16'h0028);
    w = '{3'h3, 2'h0, 13'h0005, 16'h0000, 2'h3, 1'b0, 16'h0000};
    acc(w);
    chk(dout & 16'h0003, 16'h0002);
    w = '{3'h4, 2'h0, 13'h0005, 16'h0000, 2'h0, 1'b0, 16'h0000};
    acc(w);
    chk({15'h0, f1_n}, 16'h0001);
    // sequential deselect while the random port reads the array
    @(posedge clk);
    sel_n <= 1'b1;
    acc(rows[10]);
    chk({15'h0, spd}, 16'h0001);
    chk(dout, 16'h56cd);
    give_verdict();
  end
endmodule : random_port_access_decode_tb_top
`default_nettype wire

// [sim/rpd_host.sv]
// rpd_host: host model driving the random port pins.
// assumes the bench gives one operation code per access on clk.
`default_nettype none
module rpd_host
  import rpd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [2:0]        op,
  input  wire logic [1:0]        lanes_n,
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic [DATA_W-1:0] d,
  output logic                   port_select_n,
  output logic                   cmd_select_n,
  output logic                   write_not_read,
  output logic                   output_drive_n,
  output logic                   low_lane_n,
  output logic                   high_lane_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // op: 0 idle, 1 read, 2 write, 3 cmd read, 4 cmd write, 5 read oe off
  // pins are unknown until the first edge; the block is in reset then
  always @(posedge clk) begin
    port_select_n <= !(op inside {3'h1, 3'h2, 3'h5});
    cmd_select_n <= !(op inside {3'h3, 3'h4});
    write_not_read <= !(op inside {3'h2, 3'h4});
    output_drive_n <= op inside {3'h0, 3'h2, 3'h4, 3'h5};
    {high_lane_n, low_lane_n} <= lanes_n;
    addr <= a;
    // released bus shows the inverse so stale data never looks valid
    data_in <= (op inside {3'h2, 3'h4}) ? d : ~d;
  end
endmodule : rpd_host
`default_nettype wire
